// ---- src/umi_defs.svh ----
// offsets, field positions and reset values of the pin-logic block
`ifndef UMI_DEFS_SVH
`define UMI_DEFS_SVH

// ==========================================================
// per-channel host port register offsets
`define UMI_OFF_IER 3'h1
`define UMI_OFF_MCR 3'h4
`define UMI_OFF_MSR 3'h6

// ==========================================================
// field positions
`define UMI_MCR_DTR 0
`define UMI_MCR_IRQ_EN 3
`define UMI_IER_RX_AVAIL 0
`define UMI_IER_TX_SPACE 1
`define UMI_IER_RX_ERR 2
`define UMI_IER_MODEM 3
`define UMI_MSR_DDSR 1
`define UMI_MSR_DSR 5

// ==========================================================
// reset values
`define UMI_MCR_RST 8'h00
`define UMI_IER_RST 4'h0
`define UMI_EVT_RST 4'h0
`define UMI_MASK_RST 4'h0

// ==========================================================
// ahb-lite register byte offsets
`define UMI_AHB_EVT_STATUS 12'h000
`define UMI_AHB_EVT_MASK 12'h004
`define UMI_AHB_CHAN_STATE 12'h008

`endif

// ---- src/umi_pkg.sv ----
// types shared by the pin-logic block
package umi_pkg;
    typedef logic [7:0] umi_byte_t;
    typedef logic [2:0] umi_addr_t;
    typedef logic [3:0] umi_quad_t;
    typedef enum {UMI_AHB_NONE, UMI_AHB_RD, UMI_AHB_WR} umi_dphase_t;
endpackage

// ---- src/umi_chan_if.sv ----
// strobes and data between host port decode and one channel
`timescale 1ns/10ps
interface umi_chan_if;
    import umi_pkg::*;
    logic wr_stb;
    logic rd_stb;
    umi_addr_t addr;
    umi_byte_t wdata;
    umi_byte_t rdata;
    logic irq_level;
    logic dtr_n;
    modport host (
        output wr_stb,
        output rd_stb,
        output addr,
        output wdata,
        input rdata,
        input irq_level,
        input dtr_n
    );
    modport chan (
        input wr_stb,
        input rd_stb,
        input addr,
        input wdata,
        output rdata,
        output irq_level,
        output dtr_n
    );
endinterface

// ---- src/umi_chan.sv ----
// one channel: terminal-ready, interrupt gating and modem status
`timescale 1ns/10ps
`include "umi_defs.svh"
module umi_chan (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dev_reset,
    input wire logic irq_force_select,
    input wire logic dsr_n,
    input wire logic rx_error,
    input wire logic rx_data_avail,
    input wire logic tx_space_avail,
    output logic terminal_ready_n,
    output logic channel_irq_out,
    output logic channel_irq_oe,
    umi_chan_if.chan cbus
);
    import umi_pkg::*;

    // ==========================================================
    // registers
    umi_byte_t mcr_reg, mcr_next;
    logic [3:0] ier_reg, ier_next;
    logic ddsr_reg, ddsr_next;
    logic dsr_prev_reg;
    logic dsr_seen_reg;
    logic dtr_n_reg, dtr_n_next;
    logic irq_reg, irq_next;
    logic oe_reg, oe_next;
    logic [3:0] pend;

    always_comb begin
        mcr_next = mcr_reg;
        ier_next = ier_reg;
        if (cbus.wr_stb && cbus.addr == `UMI_OFF_MCR) begin
            mcr_next = cbus.wdata;
        end
        if (cbus.wr_stb && cbus.addr == `UMI_OFF_IER) begin
            ier_next = cbus.wdata[3:0];
        end
        // a dsr edge in the clearing read still sets the flag
        ddsr_next = ddsr_reg;
        if (cbus.rd_stb && cbus.addr == `UMI_OFF_MSR) begin
            ddsr_next = 1'b0;
        end
        // first sample after reset only primes the edge detector
        if (dsr_seen_reg && dsr_n != dsr_prev_reg) begin
            ddsr_next = 1'b1;
        end
        pend = 4'h0;
        pend[`UMI_IER_RX_AVAIL] = rx_data_avail;
        pend[`UMI_IER_TX_SPACE] = tx_space_avail;
        pend[`UMI_IER_RX_ERR] = rx_error;
        pend[`UMI_IER_MODEM] = ddsr_reg;
        irq_next = |(pend & ier_reg);
        dtr_n_next = ~mcr_reg[`UMI_MCR_DTR];
        // undriven select pin is pulled low at the pad
        oe_next = irq_force_select | mcr_reg[`UMI_MCR_IRQ_EN];
        if (dev_reset) begin
            mcr_next = `UMI_MCR_RST;
            ier_next = `UMI_IER_RST;
            ddsr_next = 1'b0;
            irq_next = 1'b0;
            dtr_n_next = 1'b1;
            oe_next = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mcr_reg <= `UMI_MCR_RST;
            ier_reg <= `UMI_IER_RST;
            ddsr_reg <= 1'b0;
            dsr_prev_reg <= 1'b1;
            dsr_seen_reg <= 1'b0;
            dtr_n_reg <= 1'b1;
            irq_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            mcr_reg <= mcr_next;
            ier_reg <= ier_next;
            ddsr_reg <= ddsr_next;
            dsr_prev_reg <= dsr_n;
            dsr_seen_reg <= 1'b1;
            dtr_n_reg <= dtr_n_next;
            irq_reg <= irq_next;
            oe_reg <= oe_next;
        end
    end

    always_comb begin
        cbus.rdata = 8'h00;
        unique case (cbus.addr)
            `UMI_OFF_IER: cbus.rdata = {4'h0, ier_reg};
            `UMI_OFF_MCR: cbus.rdata = mcr_reg;
            `UMI_OFF_MSR: begin
                cbus.rdata[`UMI_MSR_DSR] = ~dsr_n;
                cbus.rdata[`UMI_MSR_DDSR] = ddsr_reg;
            end
            default: cbus.rdata = 8'h00;
        endcase
    end

    assign terminal_ready_n = dtr_n_reg;
    assign channel_irq_out = irq_reg;
    assign channel_irq_oe = oe_reg;
    assign cbus.irq_level = irq_reg;
    assign cbus.dtr_n = dtr_n_reg;

    // ==========================================================
    // assertions
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn || dev_reset);

    a_dtr_set_low: assert property (
        cbus.wr_stb && cbus.addr == `UMI_OFF_MCR && cbus.wdata[0]
        |-> ##2 !terminal_ready_n) else $error("dtr not driven low");
    a_dtr_release: assert property (
        cbus.wr_stb && cbus.addr == `UMI_OFF_MCR && !cbus.wdata[0]
        |-> ##2 terminal_ready_n) else $error("dtr not released");
    a_reset_outputs: assert property (disable iff (!hresetn)
        dev_reset |=> terminal_ready_n && !channel_irq_oe &&
        !channel_irq_out) else $error("reset state wrong");
    a_irq_hiz_gate: assert property (
        !irq_force_select && !mcr_reg[`UMI_MCR_IRQ_EN] |=> !channel_irq_oe)
        else $error("irq driven while disabled");
    a_irq_en_drive: assert property (
        mcr_reg[`UMI_MCR_IRQ_EN] |=> channel_irq_oe)
        else $error("irq not driven while enabled");
    a_irq_force_on: assert property (
        irq_force_select |=> channel_irq_oe) else $error("force ignored");
    a_irq_masked: assert property (
        ier_reg == 4'h0 |=> !channel_irq_out) else $error("masked irq");
    a_ddsr_sticky: assert property (
        $changed(dsr_n) && dsr_seen_reg |=> ddsr_reg)
        else $error("dsr change lost");
    c_dtr_low: cover property (!terminal_ready_n);
    c_irq_enabled: cover property (channel_irq_oe && channel_irq_out);
endmodule

// ---- src/umi_top.sv ----
// pin logic of a four-channel uart with host port and ahb-lite summary
// Contract
// - each channel has its own active-low terminal-ready output
// - writing one to control bit 0 drives terminal-ready low
// - writing zero to control bit 0, or reset, returns it high
// - four active-high interrupt outputs, one per channel, own state only
// - select low: interrupt driven only when control bit 3 is one
// - each interrupt source asserts only when its enable bit is set
// - sources: receive error, receive data, transmit space, modem change
// - after reset all interrupt outputs are high impedance
// - select high keeps all interrupt outputs enabled regardless of bit 3
// - select low: interrupt output enable follows control bit 3
// - select pin defaults low when undriven or absent
// - read strobe falling edge puts addressed register on data bus
// - data-set-ready level readable in the modem status register
// - write strobe rising edge stores data bus into addressed register
// - active-high reset returns registers and outputs to reset state; dev_reset leaves evt_reg, mask_reg and irq unchanged
`timescale 1ns/10ps
`include "umi_defs.svh"
module umi_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic dev_reset,
    input wire umi_pkg::umi_quad_t chan_sel_n,
    input wire umi_pkg::umi_addr_t host_addr,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire umi_pkg::umi_byte_t host_data_in,
    output umi_pkg::umi_byte_t host_data_out,
    output logic host_data_oe,
    input wire logic irq_force_select,
    input wire umi_pkg::umi_quad_t dsr_n,
    input wire umi_pkg::umi_quad_t rx_error,
    input wire umi_pkg::umi_quad_t rx_data_avail,
    input wire umi_pkg::umi_quad_t tx_space_avail,
    output umi_pkg::umi_quad_t terminal_ready_n,
    output umi_pkg::umi_quad_t channel_irq_out,
    output umi_pkg::umi_quad_t channel_irq_oe
);
    import umi_pkg::*;

    // word decode shared by the address-phase read decode and the data-phase mask write
    function automatic logic word_hit(input logic [31:0] a,
                                      input logic [11:0] off);
        word_hit = (a[11:2] == off[11:2]);
    endfunction

    // ==========================================================
    // host parallel port strobes
    logic rd_prev_reg, wr_prev_reg;
    umi_addr_t lat_addr_reg, lat_addr_next;
    umi_byte_t lat_data_reg, lat_data_next;
    umi_quad_t lat_cs_reg, lat_cs_next;
    umi_byte_t dout_reg, dout_next;
    logic doe_reg, doe_next;
    logic rd_fall, wr_rise;
    umi_byte_t rd_mux;
    umi_byte_t rdata_w [4];
    umi_quad_t irq_lvl_w, dtr_n_w;

    umi_chan_if cbus [4] ();

    assign rd_fall = rd_prev_reg & ~host_read_strobe_n;
    assign wr_rise = ~wr_prev_reg & host_write_strobe_n;

    always_comb begin
        lat_addr_next = lat_addr_reg;
        lat_data_next = lat_data_reg;
        lat_cs_next = lat_cs_reg;
        // hold what the host drove while the strobe was low, so the
        // commit on the rising edge does not race data removal
        if (!host_write_strobe_n) begin
            lat_addr_next = host_addr;
            lat_data_next = host_data_in;
            lat_cs_next = chan_sel_n;
        end
        rd_mux = 8'h00;
        for (int i = 0; i < 4; i++) begin
            if (!chan_sel_n[i]) begin
                rd_mux = rd_mux | rdata_w[i];
            end
        end
        dout_next = dout_reg;
        doe_next = doe_reg;
        if (rd_fall && chan_sel_n != 4'hF) begin
            dout_next = rd_mux;
            doe_next = 1'b1;
        end else if (host_read_strobe_n) begin
            doe_next = 1'b0;
        end
        if (dev_reset) begin
            doe_next = 1'b0;
            dout_next = 8'h00;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_prev_reg <= 1'b1;
            wr_prev_reg <= 1'b1;
            lat_addr_reg <= 3'h0;
            lat_data_reg <= 8'h00;
            lat_cs_reg <= 4'hF;
            dout_reg <= 8'h00;
            doe_reg <= 1'b0;
        end else begin
            rd_prev_reg <= host_read_strobe_n;
            wr_prev_reg <= host_write_strobe_n;
            lat_addr_reg <= lat_addr_next;
            lat_data_reg <= lat_data_next;
            lat_cs_reg <= lat_cs_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
        end
    end

    assign host_data_out = dout_reg;
    assign host_data_oe = doe_reg;

    // ==========================================================
    // channel instances
    for (genvar g = 0; g < 4; g++) begin : gen_chan
        // only the selected channel sees a strobe
        assign cbus[g].wr_stb = wr_rise & ~lat_cs_reg[g];
        assign cbus[g].rd_stb = rd_fall & ~chan_sel_n[g];
        assign cbus[g].addr = wr_rise ? lat_addr_reg : host_addr;
        assign cbus[g].wdata = lat_data_reg;
        assign rdata_w[g] = cbus[g].rdata;
        assign irq_lvl_w[g] = cbus[g].irq_level;
        assign dtr_n_w[g] = cbus[g].dtr_n;
        umi_chan u_chan (
            .hclk(hclk),
            .hresetn(hresetn),
            .dev_reset(dev_reset),
            .irq_force_select(irq_force_select),
            .dsr_n(dsr_n[g]),
            .rx_error(rx_error[g]),
            .rx_data_avail(rx_data_avail[g]),
            .tx_space_avail(tx_space_avail[g]),
            .terminal_ready_n(terminal_ready_n[g]),
            .channel_irq_out(channel_irq_out[g]),
            .channel_irq_oe(channel_irq_oe[g]),
            .cbus(cbus[g])
        );
    end

    // ==========================================================
    // ahb-lite slave: event status, mask and channel state
    umi_dphase_t dp_reg, dp_next;
    logic [11:0] dp_addr_reg, dp_addr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    umi_quad_t evt_reg, evt_next;
    umi_quad_t mask_reg, mask_next;
    umi_quad_t irq_prev_reg;
    umi_quad_t mask_now;
    logic ap_valid;

    assign ap_valid = hsel & htrans[1] & hready;

    always_comb begin
        dp_next = UMI_AHB_NONE;
        dp_addr_next = dp_addr_reg;
        mask_next = mask_reg;
        if (dp_reg == UMI_AHB_WR &&
            word_hit({20'h00000, dp_addr_reg}, `UMI_AHB_EVT_MASK)) begin
            mask_next = hwdata[3:0];
        end
        // a read right after a mask write sees the new value
        mask_now = mask_next;
        hrdata_next = hrdata_reg;
        evt_next = evt_reg;
        if (ap_valid) begin
            dp_next = hwrite ? UMI_AHB_WR : UMI_AHB_RD;
            dp_addr_next = haddr[11:0];
            if (!hwrite) begin
                hrdata_next = 32'h0000_0000;
                if (word_hit(haddr, `UMI_AHB_EVT_STATUS)) begin
                    hrdata_next[3:0] = evt_reg;
                    evt_next = `UMI_EVT_RST;
                end else if (word_hit(haddr, `UMI_AHB_EVT_MASK)) begin
                    hrdata_next[3:0] = mask_now;
                end else if (word_hit(haddr, `UMI_AHB_CHAN_STATE)) begin
                    hrdata_next[11:0] = {channel_irq_oe, dtr_n_w,
                                         irq_lvl_w};
                end
            end
        end
        // rising channel interrupt wins over a clearing read
        evt_next = evt_next | (irq_lvl_w & ~irq_prev_reg);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_reg <= UMI_AHB_NONE;
            dp_addr_reg <= 12'h000;
            hrdata_reg <= 32'h0000_0000;
            evt_reg <= `UMI_EVT_RST;
            mask_reg <= `UMI_MASK_RST;
            irq_prev_reg <= 4'h0;
        end else begin
            dp_reg <= dp_next;
            dp_addr_reg <= dp_addr_next;
            hrdata_reg <= hrdata_next;
            evt_reg <= evt_next;
            mask_reg <= mask_next;
            irq_prev_reg <= irq_lvl_w;
        end
    end

    // zero wait state slave, always okay
    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(evt_reg & mask_reg);

    // ==========================================================
    // assertions
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn || dev_reset);

    // host port side
    a_read_drive: assert property (
        rd_fall && chan_sel_n != 4'hF
        |=> host_data_oe && host_data_out == $past(rd_mux))
        else $error("read not driven");

    a_read_release: assert property (
        host_read_strobe_n |=> !host_data_oe)
        else $error("bus held after read");

    a_read_hold: assert property (
        host_data_oe && !host_read_strobe_n |=> host_data_oe)
        else $error("read data dropped early");

    a_read_unselected: assert property (
        rd_fall && chan_sel_n == 4'hF && !host_data_oe |=> !host_data_oe)
        else $error("unselected read drove bus");

    a_write_commit: assert property (
        wr_rise && !lat_cs_reg[0] && lat_addr_reg == `UMI_OFF_MCR
        |=> gen_chan[0].u_chan.mcr_reg == $past(lat_data_reg))
        else $error("write lost");

    a_write_isolated: assert property (
        wr_rise && lat_cs_reg[1]
        |=> $stable(gen_chan[1].u_chan.mcr_reg))
        else $error("write reached other channel");

    a_force_all: assert property (
        irq_force_select |=> channel_irq_oe == 4'hF)
        else $error("force not on every channel");

    a_reset_bus: assert property (disable iff (!hresetn)
        dev_reset |=> !host_data_oe) else $error("bus driven in reset");

    // bus side
    a_evt_capture: assert property (
        irq_lvl_w[0] && !irq_prev_reg[0] |=> evt_reg[0])
        else $error("event lost");

    a_evt_sticky: assert property (
        evt_reg[1] && !(ap_valid && !hwrite &&
        word_hit(haddr, `UMI_AHB_EVT_STATUS)) |=> evt_reg[1])
        else $error("event dropped");

    a_irq_output: assert property (
        ap_valid && !hwrite && word_hit(haddr, `UMI_AHB_EVT_STATUS) &&
        (irq_lvl_w & ~irq_prev_reg) == 4'h0 |=> !irq)
        else $error("irq level wrong");

    a_chan_state: assert property (
        ap_valid && !hwrite && word_hit(haddr, `UMI_AHB_CHAN_STATE)
        |=> hrdata[11:0] == $past({channel_irq_oe, terminal_ready_n,
                                   channel_irq_out}))
        else $error("channel state read wrong");

    a_mask_write: assert property (
        dp_reg == UMI_AHB_WR &&
        word_hit({20'h00000, dp_addr_reg}, `UMI_AHB_EVT_MASK)
        |=> mask_reg == $past(hwdata[3:0]))
        else $error("mask write lost");

    a_unmapped_read: assert property (
        ap_valid && !hwrite && haddr[11:2] > 10'h002
        |=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");

    c_host_write: cover property (wr_rise && lat_cs_reg != 4'hF);
    c_host_read: cover property (rd_fall ##1 host_data_oe);
    c_ahb_irq: cover property (irq);
endmodule

// ---- tb/umi_host_model.sv ----
// host cpu model driving the parallel port of the pin-logic block
`timescale 1ns/10ps
module umi_host_model (
    input wire logic hclk,
    output umi_pkg::umi_quad_t chan_sel_n,
    output umi_pkg::umi_addr_t host_addr,
    output logic host_read_strobe_n,
    output logic host_write_strobe_n,
    output umi_pkg::umi_byte_t host_data_in
);
    import umi_pkg::*;
    // ==========================================================
    // idle levels
    initial begin
        chan_sel_n = 4'hF;
        host_addr = 3'h0;
        host_read_strobe_n = 1'b1;
        host_write_strobe_n = 1'b1;
        host_data_in = 8'h00;
    end
    // ==========================================================
    // bus cycles
    // released address and data lines flip and selects go high, so a stale value can never pass for a live one
    task automatic release_bus();
        @(posedge hclk);
        chan_sel_n <= 4'hF;
        host_addr <= ~host_addr;
        host_data_in <= ~host_data_in;
        @(posedge hclk);
    endtask
    task automatic wr(input int ch, input umi_addr_t a, input umi_byte_t d);
        @(posedge hclk);
        chan_sel_n <= ~(4'h1 << ch);
        host_addr <= a;
        host_data_in <= d;
        host_write_strobe_n <= 1'b0;
        repeat (2) @(posedge hclk);
        host_write_strobe_n <= 1'b1;
        release_bus();
    endtask
    task automatic rd(input int ch, input umi_addr_t a);
        @(posedge hclk);
        chan_sel_n <= ~(4'h1 << ch);
        host_addr <= a;
        host_read_strobe_n <= 1'b0;
        repeat (3) @(posedge hclk);
        host_read_strobe_n <= 1'b1;
        release_bus();
    endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the pin-logic block
`timescale 1ns/10ps
`include "umi_defs.svh"
module tb;
    import umi_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hresp, irq, dev_reset, hreadyout;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic host_data_oe, host_read_strobe_n, host_write_strobe_n;
    logic irq_force_select, irq_m;
    umi_quad_t chan_sel_n, dsr_n, rx_error, rx_data_avail, tx_space_avail;
    umi_quad_t terminal_ready_n, channel_irq_out, channel_irq_oe, delta_m;
    umi_addr_t host_addr;
    umi_byte_t host_data_in, host_data_out;
    umi_byte_t mcr_m[4];
    umi_byte_t ier_m[4];
    umi_byte_t par_q[$];
    logic [31:0] ahb_q[$];
    logic [31:0] msk_q[$];
    int err_count = 0;
    int total_checks = 0;
    int seed = 80;
    logic rd_dp = 1'b0;
    logic oe_prev = 1'b0;

    umi_top umi_top_inst (.*, .hready(hreadyout));
    umi_host_model umi_host_model_inst (.*);

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // ==========================================================
    // comparison and verdict
    task automatic results();
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic note(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t %s mismatch", $time, what);
        end
    endtask
    task automatic cmp_pins(input logic [12:0] got, input logic [12:0] exp);
        note(got === exp, "pins");
    endtask
    task automatic cmp_byte(input umi_byte_t got, input umi_byte_t exp);
        note(got === exp, "port read");
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
                            input logic [31:0] msk);
        note((got & msk) === (exp & msk) && hresp === 1'b0, "bus read");
    endtask
    // ==========================================================
    // expected pin state from the bench's own register copies
    function automatic logic [12:0] exp_pins();
        logic [12:0] v;
        v = {irq_m, 12'h000};
        for (int i = 0; i < 4; i++) begin
            v[8+i] = irq_force_select | mcr_m[i][`UMI_MCR_IRQ_EN];
            v[4+i] = ~mcr_m[i][`UMI_MCR_DTR];
            v[i] = |({rx_error[i], tx_space_avail[i], rx_data_avail[i]}
                     & ier_m[i][2:0]) | (ier_m[i][3] & delta_m[i]);
        end
        return v;
    endfunction
    task automatic check_pins();
        repeat (4) @(posedge hclk);
        #1;
        cmp_pins({irq, channel_irq_oe, terminal_ready_n, channel_irq_out},
                 exp_pins());
    endtask
    // ==========================================================
    // drivers
    task automatic pwr(input int ch, input umi_addr_t a, input umi_byte_t d);
        umi_host_model_inst.wr(ch, a, d);
        if (a == `UMI_OFF_MCR) mcr_m[ch] = d;
        if (a == `UMI_OFF_IER) ier_m[ch] = d & 8'h0F;
    endtask
    task automatic prd(input int ch, input umi_addr_t a, input umi_byte_t e);
        par_q.push_back(e);
        umi_host_model_inst.rd(ch, a);
        if (a == `UMI_OFF_MSR) delta_m[ch] = 1'b0;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_count++;
                results();
            end
            @(posedge hclk);
        end
    endtask
    // for a read, d is the expected word and m the bits that matter
    task automatic ahb(input logic [11:0] a, input logic w,
                       input logic [31:0] d, input logic [31:0] m);
        if (!w) ahb_q.push_back(d);
        if (!w) msk_q.push_back(m);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h00000, a};
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask
    task automatic rand_pend();
        logic [31:0] r;
        r = $random(seed);
        rx_error <= r[3:0];
        rx_data_avail <= r[7:4];
        tx_space_avail <= r[11:8];
    endtask
    // ==========================================================
    // result monitor: oldest note against each result that appears
    always @(posedge hclk) begin
        if (rd_dp && hreadyout)
            cmp_word(hrdata, ahb_q.pop_front(), msk_q.pop_front());
        rd_dp = hsel && htrans[1] && !hwrite && hreadyout;
        if (host_data_oe && !oe_prev)
            cmp_byte(host_data_out, par_q.pop_front());
        oe_prev = host_data_oe;
    end
    initial begin
        repeat (50000) @(posedge hclk);
        err_count++;
        results();
    end
    // ==========================================================
    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        dev_reset = 1'b0;
        irq_force_select = 1'b0;
        irq_m = 1'b0;
        dsr_n = 4'hA;
        delta_m = 4'h0;
        rx_error = 4'h5;
        rx_data_avail = 4'h3;
        tx_space_avail = 4'hC;
        for (int i = 0; i < 4; i++) begin
            mcr_m[i] = 8'h00;
            ier_m[i] = 8'h00;
        end
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        check_pins();
        for (int i = 0; i < 4; i++) begin
            pwr(i, `UMI_OFF_MCR, 8'h09);
            check_pins();
        end
        pwr(0, `UMI_OFF_MCR, 8'h00);
        pwr(1, `UMI_OFF_MCR, 8'h01);
        pwr(2, `UMI_OFF_MCR, 8'h08);
        check_pins();
        for (int i = 0; i < 4; i++) begin
            prd(i, `UMI_OFF_MCR, mcr_m[i]);
        end
        irq_force_select <= 1'b1;
        check_pins();
        irq_force_select <= 1'b0;
        check_pins();
        // each non-modem source code (enable bits 0 to 2) on varying channels, random pending levels
        for (int k = 0; k < 9; k++) begin
            pwr(k % 4, `UMI_OFF_IER, umi_byte_t'(1 << (k % 3)));
            rand_pend();
            check_pins();
        end
        prd(1, `UMI_OFF_IER, ier_m[1]);
        pwr(0, `UMI_OFF_IER, 8'h08);
        dsr_n[0] <= ~dsr_n[0];
        delta_m[0] = 1'b1;
        check_pins();
        prd(0, `UMI_OFF_MSR, {2'b00, ~dsr_n[0], 5'b00010});
        check_pins();
        prd(0, `UMI_OFF_MSR, {2'b00, ~dsr_n[0], 5'b00000});
        // summary interrupt: raised while masked, unmasked, read-cleared
        rx_error <= 4'h0;
        rx_data_avail <= 4'h0;
        tx_space_avail <= 4'h0;
        pwr(1, `UMI_OFF_IER, 8'h01);
        ahb(`UMI_AHB_EVT_STATUS, 1'b0, 32'h0, 32'h0);
        rx_data_avail <= 4'h2;
        check_pins();
        ahb(`UMI_AHB_EVT_MASK, 1'b1, 32'h2, 32'h0);
        irq_m = 1'b1;
        check_pins();
        ahb(`UMI_AHB_EVT_STATUS, 1'b0, 32'h2, 32'hF);
        irq_m = 1'b0;
        check_pins();
        ahb(`UMI_AHB_EVT_STATUS, 1'b0, 32'h0, 32'hF);
        ahb(`UMI_AHB_EVT_MASK, 1'b0, 32'h2, 32'hF);
        ahb(`UMI_AHB_CHAN_STATE, 1'b1, 32'hFFF, 32'h0);
        ahb(`UMI_AHB_CHAN_STATE, 1'b0, {19'h0, exp_pins()}, 32'hFFF);
        ahb(12'h00C, 1'b0, 32'h0, 32'hFFFFFFFF);
        // device reset in mid-run
        dev_reset <= 1'b1;
        repeat (2) @(posedge hclk);
        dev_reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            mcr_m[i] = 8'h00;
            ier_m[i] = 8'h00;
        end
        check_pins();
        repeat (10) @(posedge hclk);
        if (par_q.size() != 0 || ahb_q.size() != 0) err_count++;
        results();
    end
endmodule
